/* File: shared/hfz_pkg.sv */
/*
  Package for the debug halt freeze register bank: offsets, field
  positions, reset values and write masks.
  Assumes a 32-bit word register port with byte addresses.
*/
package hfz_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] HFZ_LOW_OFFSET = 32'h40015808;
  localparam logic [31:0] HFZ_HIGH_OFFSET = 32'h4001580C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] HFZ_LOW_RESET = 32'h00000000;
  localparam logic [31:0] HFZ_HIGH_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // Field positions, low freeze register
  // ----------------------------------------------------------------
  localparam int HFZ_TIMER_THREE_BIT = 1;
  localparam int HFZ_TIMER_SIX_BIT = 4;
  localparam int HFZ_TIMER_SEVEN_BIT = 5;
  localparam int HFZ_TIMER_FOURTEEN_BIT = 8;
  localparam int HFZ_CALENDAR_BIT = 10;
  localparam int HFZ_WINDOW_DOG_BIT = 11;
  localparam int HFZ_INDEP_DOG_BIT = 12;
  localparam int HFZ_BUS_TIMEOUT_BIT = 21;

  // ----------------------------------------------------------------
  // Field positions, high freeze register
  // ----------------------------------------------------------------
  localparam int HFZ_TIMER_ONE_BIT = 11;
  localparam int HFZ_TIMER_FIFTEEN_BIT = 16;
  localparam int HFZ_TIMER_SIXTEEN_BIT = 17;
  localparam int HFZ_TIMER_SEVENTEEN_BIT = 18;

  // ----------------------------------------------------------------
  // Writable bit masks; all other bits are reserved
  // ----------------------------------------------------------------
  localparam logic [31:0] HFZ_LOW_MASK = 32'h00201D32;
  localparam logic [31:0] HFZ_HIGH_MASK = 32'h00070800;

endpackage

/* File: rtl/hfz_reg.sv */
/*
  One freeze register: a 32-bit word with a writable mask, cleared
  only by the power-on reset.
  Assumes the write strobe is synchronous to core_clk_in.
*/
`timescale 1ns/1ps

module hfz_reg #(
  parameter logic [31:0] MASK = 32'h00000000,
  parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
  // Clock and power-on reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic [31:0] wr_data_in,
  // Stored value
  output logic [31:0] value_out
);

  // Masked storage; every write loads zero into the reserved bits
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      value_out <= RESET_VALUE;
    else if (wr_en_in)
      value_out <= wr_data_in & MASK;
  end

endmodule

/* File: rtl/hfz_top.sv */
/*
  Debug halt freeze register bank: two freeze words and the gated
  freeze outputs toward the timers, watchdogs, calendar clock and the
  serial-bus timeout logic.
  Assumes a plain register port on core_clk_in, a halt level from
  logic on the same clock, and a separate system reset that this
  block deliberately ignores.
*/
// Our own choice: the plain strobed port.
// Function
// RULE1: Freeze words cleared only by power-on reset, never by system reset.
// RULE2: Both freeze words read zero after power-on.
// RULE3: Writes during system reset are accepted and kept.
// RULE4: Software uses full 32-bit word accesses only.
// RULE5: Low word bit 1 stops timer three during halt.
// RULE6: Low word bit 4 stops timer six during halt.
// RULE7: Low word bit 5 stops timer seven during halt.
// RULE8: Low word bit 8 stops timer fourteen during halt.
// RULE9: Low word bit 10 stops calendar clock during halt.
// RULE10: Low word bit 11 stops window watchdog during halt.
// RULE11: Low word bit 12 stops independent watchdog during halt.
// RULE12: Low word bit 21 freezes bus timeout detection during halt.
// RULE13: High word bit 11 stops timer one during halt.
// RULE14: High word bit 16 stops timer fifteen during halt.
// RULE15: High word bit 17 stops timer sixteen during halt.
// RULE16: High word bit 18 stops timer seventeen during halt.
// RULE17: Freeze outputs only while halted and bit set; drop on resume.
// RULE18: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps

module hfz_top (
  // Clock and power-on reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // System reset, seen only so writes during it stay legal
  input wire logic sys_rst_b_in,
  // Register port
  input wire logic [31:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Core halt level from the debug logic
  input wire logic core_halted_in,
  // Freeze outputs, low word peripherals
  output logic timer_three_halt_stop_out,
  output logic timer_six_halt_stop_out,
  output logic timer_seven_halt_stop_out,
  output logic timer_fourteen_halt_stop_out,
  output logic calendar_clock_halt_stop_out,
  output logic window_dog_halt_stop_out,
  output logic independent_dog_halt_stop_out,
  output logic bus_timeout_halt_stop_out,
  // Freeze outputs, high word peripherals
  output logic timer_one_halt_stop_out,
  output logic timer_fifteen_halt_stop_out,
  output logic timer_sixteen_halt_stop_out,
  output logic timer_seventeen_halt_stop_out
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  logic sel_low;
  logic sel_high;
  logic wr_low;
  logic wr_high;
  logic [31:0] low_word;
  logic [31:0] high_word;
  logic [31:0] next_rdata;

  // Full word match; byte lanes do not exist on this port
  // A narrow or offset access misses the match and is dropped
  assign sel_low = (reg_addr_in == hfz_pkg::HFZ_LOW_OFFSET); // [RULE4]
  assign sel_high = (reg_addr_in == hfz_pkg::HFZ_HIGH_OFFSET);
  // System reset is not part of the write term on purpose
  assign wr_low = reg_wr_in && sel_low; // [RULE3]
  assign wr_high = reg_wr_in && sel_high; // [RULE3]

  // ----------------------------------------------------------------
  // Freeze words
  // ----------------------------------------------------------------

  // Low word: timers, calendar clock, watchdogs, bus timeout
  hfz_reg #(
    .MASK(hfz_pkg::HFZ_LOW_MASK),
    .RESET_VALUE(hfz_pkg::HFZ_LOW_RESET)
  ) u_low (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in), // [RULE1] [RULE2]
    .wr_en_in(wr_low),
    .wr_data_in(reg_wdata_in), // [RULE18]
    .value_out(low_word)
  );

  // High word: advanced and general timers
  hfz_reg #(
    .MASK(hfz_pkg::HFZ_HIGH_MASK),
    .RESET_VALUE(hfz_pkg::HFZ_HIGH_RESET)
  ) u_high (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in), // [RULE1] [RULE2]
    .wr_en_in(wr_high),
    .wr_data_in(reg_wdata_in), // [RULE18]
    .value_out(high_word)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Unmapped addresses read zero
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (reg_rd_in && sel_low)
      next_rdata = low_word; // [RULE18]
    else if (reg_rd_in && sel_high)
      next_rdata = high_word; // [RULE18]
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      reg_rdata_out <= 32'h00000000;
    else
      reg_rdata_out <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Freeze outputs
  // ----------------------------------------------------------------

  // Combinational gating so release is immediate on resume
  assign timer_three_halt_stop_out = core_halted_in &&
    low_word[hfz_pkg::HFZ_TIMER_THREE_BIT]; // [RULE5] [RULE17]
  assign timer_six_halt_stop_out = core_halted_in &&
    low_word[hfz_pkg::HFZ_TIMER_SIX_BIT]; // [RULE6] [RULE17]
  assign timer_seven_halt_stop_out = core_halted_in &&
    low_word[hfz_pkg::HFZ_TIMER_SEVEN_BIT]; // [RULE7] [RULE17]
  assign timer_fourteen_halt_stop_out = core_halted_in &&
    low_word[hfz_pkg::HFZ_TIMER_FOURTEEN_BIT]; // [RULE8] [RULE17]
  assign calendar_clock_halt_stop_out = core_halted_in &&
    low_word[hfz_pkg::HFZ_CALENDAR_BIT]; // [RULE9] [RULE17]
  assign window_dog_halt_stop_out = core_halted_in &&
    low_word[hfz_pkg::HFZ_WINDOW_DOG_BIT]; // [RULE10] [RULE17]
  assign independent_dog_halt_stop_out = core_halted_in &&
    low_word[hfz_pkg::HFZ_INDEP_DOG_BIT]; // [RULE11] [RULE17]
  assign bus_timeout_halt_stop_out = core_halted_in &&
    low_word[hfz_pkg::HFZ_BUS_TIMEOUT_BIT]; // [RULE12] [RULE17]
  assign timer_one_halt_stop_out = core_halted_in &&
    high_word[hfz_pkg::HFZ_TIMER_ONE_BIT]; // [RULE13] [RULE17]
  assign timer_fifteen_halt_stop_out = core_halted_in &&
    high_word[hfz_pkg::HFZ_TIMER_FIFTEEN_BIT]; // [RULE14] [RULE17]
  assign timer_sixteen_halt_stop_out = core_halted_in &&
    high_word[hfz_pkg::HFZ_TIMER_SIXTEEN_BIT]; // [RULE15] [RULE17]
  assign timer_seventeen_halt_stop_out = core_halted_in &&
    high_word[hfz_pkg::HFZ_TIMER_SEVENTEEN_BIT]; // [RULE16] [RULE17]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_low_write(logic [31:0] d);
    reg_wr_in && sel_low && reg_wdata_in == d;
  endsequence

  // One freeze bit written, low or high word
  sequence s_low_bit_written(int b);
    reg_wr_in && sel_low && reg_wdata_in[b];
  endsequence

  sequence s_high_bit_written(int b);
    reg_wr_in && sel_high && reg_wdata_in[b];
  endsequence

  // A low-word write during system reset lands masked in the next cycle
  a_sysrst_write_kept: assert property ( // [RULE3]
    (reg_wr_in && sel_low && !sys_rst_b_in) |=>
      low_word == ($past(reg_wdata_in) & hfz_pkg::HFZ_LOW_MASK))
    else $error("write during system reset lost");

  // Reserved bits never set
  a_reserved_zero: assert property ( // [RULE18]
    ((low_word & ~hfz_pkg::HFZ_LOW_MASK) == 32'h00000000) &&
    ((high_word & ~hfz_pkg::HFZ_HIGH_MASK) == 32'h00000000))
    else $error("reserved bit set");

  // Read data follows the strobe by one cycle
  a_read_low: assert property ( // [RULE18]
    (reg_rd_in && sel_low && !reg_wr_in) |=>
      reg_rdata_out == $past(low_word))
    else $error("low word read wrong");

  a_read_high: assert property ( // [RULE18]
    (reg_rd_in && sel_high && !reg_wr_in) |=>
      reg_rdata_out == $past(high_word))
    else $error("high word read wrong");

  // Idle cycle returns zero
  a_read_idle: assert property (
    !reg_rd_in |=> reg_rdata_out == 32'h00000000)
    else $error("read data outside read cycle");

  // Timer three freeze follows halt and bit
  a_timer_three: assert property ( // [RULE5]
    (s_low_write(32'h00000002) ##1 core_halted_in) |->
      timer_three_halt_stop_out)
    else $error("timer three not frozen");

  // Resume releases every freeze at once
  a_resume_release: assert property ( // [RULE17]
    !core_halted_in |-> !(timer_three_halt_stop_out ||
      timer_six_halt_stop_out || timer_seven_halt_stop_out ||
      timer_fourteen_halt_stop_out || calendar_clock_halt_stop_out ||
      window_dog_halt_stop_out || independent_dog_halt_stop_out ||
      bus_timeout_halt_stop_out || timer_one_halt_stop_out ||
      timer_fifteen_halt_stop_out || timer_sixteen_halt_stop_out ||
      timer_seventeen_halt_stop_out))
    else $error("freeze held while running");

  // Bus timeout freeze tied to bit 21
  a_bus_timeout: assert property ( // [RULE12]
    core_halted_in |->
      bus_timeout_halt_stop_out == low_word[21])
    else $error("bus timeout freeze wrong");

  // Timer seventeen freeze tied to high bit 18
  a_timer_seventeen: assert property ( // [RULE16]
    core_halted_in |->
      timer_seventeen_halt_stop_out == high_word[18])
    else $error("timer seventeen freeze wrong");

  // Watchdog freezes tied to bits 11 and 12
  a_watchdogs: assert property ( // [RULE10] [RULE11]
    core_halted_in |->
      window_dog_halt_stop_out == low_word[11] &&
      independent_dog_halt_stop_out == low_word[12])
    else $error("watchdog freeze wrong");

  // Without a write both words hold, system reset or not
  a_words_hold: assert property ( // [RULE1]
    !reg_wr_in |=> $stable(low_word) && $stable(high_word))
    else $error("freeze word changed without a write");

  // A write lands masked in the next cycle
  a_write_low: assert property ( // [RULE18]
    (reg_wr_in && sel_low) |=>
      low_word == ($past(reg_wdata_in) & hfz_pkg::HFZ_LOW_MASK))
    else $error("low word write lost");

  a_write_high: assert property ( // [RULE18]
    (reg_wr_in && sel_high) |=>
      high_word == ($past(reg_wdata_in) & hfz_pkg::HFZ_HIGH_MASK))
    else $error("high word write lost");

  // ----------------------------------------------------------------
  // Per-peripheral freeze checks: bit written, then halted
  // ----------------------------------------------------------------

  // Timer six stops once its bit is in and the core halts
  a_timer_six: assert property ( // [RULE6]
    (s_low_bit_written(hfz_pkg::HFZ_TIMER_SIX_BIT) ##1
      core_halted_in) |-> timer_six_halt_stop_out)
    else $error("timer six not frozen");

  // Timer seven likewise
  a_timer_seven: assert property ( // [RULE7]
    (s_low_bit_written(hfz_pkg::HFZ_TIMER_SEVEN_BIT) ##1
      core_halted_in) |-> timer_seven_halt_stop_out)
    else $error("timer seven not frozen");

  // Timer fourteen likewise
  a_timer_fourteen: assert property ( // [RULE8]
    (s_low_bit_written(hfz_pkg::HFZ_TIMER_FOURTEEN_BIT) ##1
      core_halted_in) |-> timer_fourteen_halt_stop_out)
    else $error("timer fourteen not frozen");

  // Calendar clock likewise
  a_calendar_clock: assert property ( // [RULE9]
    (s_low_bit_written(hfz_pkg::HFZ_CALENDAR_BIT) ##1
      core_halted_in) |-> calendar_clock_halt_stop_out)
    else $error("calendar clock not frozen");

  // Timer one, high word
  a_timer_one: assert property ( // [RULE13]
    (s_high_bit_written(hfz_pkg::HFZ_TIMER_ONE_BIT) ##1
      core_halted_in) |-> timer_one_halt_stop_out)
    else $error("timer one not frozen");

  // Timer fifteen, high word
  a_timer_fifteen: assert property ( // [RULE14]
    (s_high_bit_written(hfz_pkg::HFZ_TIMER_FIFTEEN_BIT) ##1
      core_halted_in) |-> timer_fifteen_halt_stop_out)
    else $error("timer fifteen not frozen");

  // Timer sixteen, high word
  a_timer_sixteen: assert property ( // [RULE15]
    (s_high_bit_written(hfz_pkg::HFZ_TIMER_SIXTEEN_BIT) ##1
      core_halted_in) |-> timer_sixteen_halt_stop_out)
    else $error("timer sixteen not frozen");

endmodule

/* File: dv/hfz_periph_model.sv */
/*
  Model of the frozen peripherals: twelve free-running 8-bit counters,
  each held still while its freeze request is high.
  Assumes the freeze requests come from the bank on core_clk_in.
*/
`timescale 1ns/1ps

module hfz_periph_model (
  // Clock and power-on reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Freeze requests, one per peripheral
  input wire logic [11:0] freeze_in,
  // Running counts, 8 bits per peripheral
  output logic [95:0] count_out
);
  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Counters wrap freely; only the step size matters to the bench
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      count_out <= 96'h0;
    end
    else
    begin
      for (int i = 0; i < 12; i++)
      begin
        // Counter stops while frozen
        // Same for calendar, dogs, bus timeout
        // And for the high-word timers
        if (!freeze_in[i])
        begin
          count_out[i*8 +: 8] <= count_out[i*8 +: 8] + 8'h01;
        end
      end
    end
  end
endmodule

/* File: dv/tb.sv */
/*
  Self-checking bench for the halt freeze bank and peripheral model.
  Assumes one 100 MHz clock and a single-cycle register port.
*/
`timescale 1ns/1ps

module tb;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic sys_rst_b_in = 1'b0;
  logic [31:0] reg_addr_in = 32'h00000000;
  logic [31:0] reg_wdata_in = 32'h00000000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic core_halted_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [11:0] frz;
  logic [11:0] efz;
  logic [95:0] cnt;
  logic [95:0] snap;
  logic [31:0] lo;
  logic [31:0] hi;
  logic [31:0] rv;
  logic halt;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 2;

  // ----------------------------------------------------------------
  // Clock, design and far-side model
  // ----------------------------------------------------------------
  always #5 core_clk_in = ~core_clk_in;

  hfz_top i_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .sys_rst_b_in(sys_rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .core_halted_in(core_halted_in),
    .timer_three_halt_stop_out(frz[0]), .timer_six_halt_stop_out(frz[1]),
    .timer_seven_halt_stop_out(frz[2]),
    .timer_fourteen_halt_stop_out(frz[3]),
    .calendar_clock_halt_stop_out(frz[4]),
    .window_dog_halt_stop_out(frz[5]),
    .independent_dog_halt_stop_out(frz[6]),
    .bus_timeout_halt_stop_out(frz[7]), .timer_one_halt_stop_out(frz[8]),
    .timer_fifteen_halt_stop_out(frz[9]),
    .timer_sixteen_halt_stop_out(frz[10]),
    .timer_seventeen_halt_stop_out(frz[11]));

  hfz_periph_model i_model (.core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in), .freeze_in(frz), .count_out(cnt));

  // ----------------------------------------------------------------
  // Expectations, bus tasks, checks
  // ----------------------------------------------------------------
  function automatic logic [11:0] exp_frz(input logic [31:0] l,
    input logic [31:0] h, input logic hl);
    exp_frz = {h[hfz_pkg::HFZ_TIMER_SEVENTEEN_BIT],
      h[hfz_pkg::HFZ_TIMER_SIXTEEN_BIT], h[hfz_pkg::HFZ_TIMER_FIFTEEN_BIT],
      h[hfz_pkg::HFZ_TIMER_ONE_BIT], l[hfz_pkg::HFZ_BUS_TIMEOUT_BIT],
      l[hfz_pkg::HFZ_INDEP_DOG_BIT], l[hfz_pkg::HFZ_WINDOW_DOG_BIT],
      l[hfz_pkg::HFZ_CALENDAR_BIT], l[hfz_pkg::HFZ_TIMER_FOURTEEN_BIT],
      l[hfz_pkg::HFZ_TIMER_SEVEN_BIT], l[hfz_pkg::HFZ_TIMER_SIX_BIT],
      l[hfz_pkg::HFZ_TIMER_THREE_BIT]} & {12{hl}};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Whole 32-bit words only; strobe held exactly one cycle
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  // Reads both words back, applies the halt level and compares readback and freeze outputs
  task automatic check_all(input string what);
    rd(hfz_pkg::HFZ_LOW_OFFSET, rv);
    chk({what, " low"}, lo & hfz_pkg::HFZ_LOW_MASK, rv);
    rd(hfz_pkg::HFZ_HIGH_OFFSET, rv);
    chk({what, " high"}, hi & hfz_pkg::HFZ_HIGH_MASK, rv);
    @(posedge core_clk_in);
    core_halted_in <= halt;
    #1 chk({what, " freeze"}, {20'h0, exp_frz(lo, hi, halt)},
      {20'h0, frz});
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Hang guard
  // ----------------------------------------------------------------
  initial
  begin
    #1000000;
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    sys_rst_b_in <= 1'b1;
    lo = 32'h0;
    hi = 32'h0;
    halt = 1'b1;
    check_all("por");
    // Corner: timer three alone, written while already halted
    lo = 32'h00000002;
    wr(hfz_pkg::HFZ_LOW_OFFSET, lo);
    check_all("timer three alone");
    $display("test power-on values done");
    // Random words, every field set and cleared, halt both ways
    for (int i = 0; i < 24; i++)
    begin
      lo = $random(seed);
      hi = $random(seed);
      halt = i[0];
      if (i == 0) lo = 32'hFFFFFFFF;
      if (i == 0) hi = 32'hFFFFFFFF;
      wr(hfz_pkg::HFZ_LOW_OFFSET, lo);
      wr(hfz_pkg::HFZ_HIGH_OFFSET, hi);
      check_all("random");
    end
    $display("test random fields done");
    // Neighbouring addresses are unmapped: no effect, read zero
    wr(32'h40015804, 32'hFFFFFFFF);
    wr(32'h40015810, 32'hFFFFFFFF);
    rd(32'h40015810, rv);
    chk("unmapped read", 32'h0, rv);
    check_all("unmapped write");
    $display("test unmapped done");
    // Model counters stop only where frozen
    snap = cnt;
    efz = exp_frz(lo, hi, halt);
    repeat (5) @(posedge core_clk_in);
    #1;
    for (int i = 0; i < 12; i++)
      chk("count", {24'h0, snap[i*8 +: 8] + (efz[i] ? 8'h00 : 8'h05)},
        {24'h0, cnt[i*8 +: 8]});
    $display("test peripheral freeze done");
    // Writes during system reset are kept across it
    @(posedge core_clk_in);
    sys_rst_b_in <= 1'b0;
    lo = 32'h00201D32;
    hi = 32'h00070800;
    wr(hfz_pkg::HFZ_LOW_OFFSET, lo);
    wr(hfz_pkg::HFZ_HIGH_OFFSET, hi);
    repeat (4) @(posedge core_clk_in);
    sys_rst_b_in <= 1'b1;
    check_all("system reset");
    $display("test system reset done");
    // Second power-on reset in mid-run clears both words
    @(posedge core_clk_in);
    rst_b_in <= 1'b0;
    #1 chk("por freeze", 32'h0, {20'h0, frz});
    repeat (3) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    lo = 32'h0;
    hi = 32'h0;
    check_all("por again");
    $display("test mid-run power-on reset done");
    print_verdict();
  end
endmodule
